//--- hw/pdsp_dev.sv
`timescale 1ns/1ps
`include "pdsp_map.svh"

// Functional notes
// - Low chip select frames and enables port
// - Input sampled on falling clock, MSB first
// - Master keeps serial clock at most 5 MHz
// - Output released while chip select high
// - Output advances on each rising clock edge
// - Master captures output on falling clock edge
// - Low-side request active high, low is off
// - High-side request active low, high is off
// - Overcurrent flag high while overcurrent present
// - Interrupt held high until clear command
module pdsp_dev
    import pdsp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    pdsp_if.dev link,
    input wire logic [`PDSP_STAT_USER_W-1:0] status_in,
    input wire logic fault_in,
    input wire logic overcurrent_in,
    output logic cmd_valid_out,
    output pdsp_word_t cmd_data_out,
    output logic phase_c_low_on_out,
    output logic phase_c_high_on_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: reset brought over from the core
    // Serial clock stops between frames: reset enters at once, leaves on clock rises
    logic lrstn_src_q;
    logic lrstn_s1_q;
    logic lrstn_s2_q;

    always_ff @(posedge core_clk_in) begin
        lrstn_src_q <= rstn_in;
    end

    always_ff @(posedge link.sclk or negedge lrstn_src_q) begin
        if (!lrstn_src_q) begin
            lrstn_s1_q <= 1'b0;
            lrstn_s2_q <= 1'b0;
        end else begin
            lrstn_s1_q <= 1'b1;
            lrstn_s2_q <= lrstn_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path, falling edge
    pdsp_bit_idx_t icnt_q, icnt_d;
    pdsp_word_t rxsh_q, rxsh_d;
    logic rx_done;

    always_comb begin
        icnt_d = icnt_q + 3'h1;
        rxsh_d = {rxsh_q[6:0], link.mosi};
        rx_done = (icnt_q == 3'h7);
    end

    // Chip select high clears the count, so a new frame starts at bit 0
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            icnt_q <= 3'h0;
            rxsh_q <= 8'h00;
        end else begin
            icnt_q <= icnt_d;
            rxsh_q <= rxsh_d;
        end
    end

    pdsp_word_t rxword_q, rxword_d;
    logic rxtog_q, rxtog_d;

    always_comb begin
        rxword_d = rxword_q;
        rxtog_d = rxtog_q;
        if (rx_done) begin
            rxword_d = rxsh_d;
            rxtog_d = ~rxtog_q;
        end
    end

    // Word and toggle survive chip select so the core can still pick them up
    always_ff @(negedge link.sclk or negedge lrstn_s2_q) begin
        if (!lrstn_s2_q) begin
            rxword_q <= 8'h00;
            rxtog_q <= 1'b0;
        end else if (!link.cs_n) begin
            rxword_q <= rxword_d;
            rxtog_q <= rxtog_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path, rising edge
    logic req_s1_q;
    logic req_s2_q;
    logic ack_q, ack_d;
    pdsp_word_t hold_q, hold_d;
    pdsp_word_t sent_q;
    logic req_q;

    always_comb begin
        ack_d = ack_q;
        hold_d = hold_q;
        if (req_s2_q != ack_q) begin
            hold_d = sent_q;
            ack_d = req_s2_q;
        end
    end

    always_ff @(posedge link.sclk) begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
    end

    always_ff @(posedge link.sclk or negedge lrstn_s2_q) begin
        if (!lrstn_s2_q) begin
            ack_q <= 1'b0;
            hold_q <= `PDSP_STAT_RST;
        end else begin
            ack_q <= ack_d;
            hold_q <= hold_d;
        end
    end

    pdsp_bit_idx_t ocnt_q, ocnt_d;
    pdsp_word_t txsh_q, txsh_d;
    logic so_q, so_d;
    logic so_oe_q;

    always_comb begin
        ocnt_d = ocnt_q + 3'h1;
        if (ocnt_q == 3'h0) begin
            so_d = hold_q[7];
            txsh_d = {hold_q[6:0], 1'b0};
        end else begin
            so_d = txsh_q[7];
            txsh_d = {txsh_q[6:0], 1'b0};
        end
    end

    // Output enable drops with chip select, without waiting for a clock
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            ocnt_q <= 3'h0;
            txsh_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            ocnt_q <= ocnt_d;
            txsh_q <= txsh_d;
            so_q <= so_d;
            so_oe_q <= 1'b1;
        end
    end

    assign link.so = so_q;
    assign link.so_oe = so_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: pin synchronisers
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic rtog_s3_q;

    always_ff @(posedge core_clk_in) begin
        pin_s1_q <= {rxtog_q, link.phase_c_low_side_request,
                     link.phase_c_high_side_request_n, fault_in, overcurrent_in};
        pin_s2_q <= pin_s1_q;
        rtog_s3_q <= pin_s2_q[4];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: commands, interrupt, flags, status hand-off
    logic cmd_valid_q, cmd_valid_d;
    pdsp_word_t cmd_data_q, cmd_data_d;
    logic int_q, int_d;
    logic oc_q, oc_d;
    logic ls_on_q, ls_on_d;
    logic hs_on_q, hs_on_d;
    logic ack_s1_q;
    logic ack_s2_q;
    logic req_d;
    pdsp_word_t sent_d;
    pdsp_word_t stat_now;
    logic clr_int;

    always_comb begin
        cmd_valid_d = (pin_s2_q[4] != rtog_s3_q);
        cmd_data_d = cmd_valid_d ? rxword_q : cmd_data_q;
        clr_int = cmd_valid_q && (cmd_data_q == `PDSP_CMD_CLR_INT);
        // A fault in the clearing cycle keeps the line high
        int_d = pin_s2_q[1] | (int_q & ~clr_int);
        oc_d = pin_s2_q[0];
        ls_on_d = pin_s2_q[3];
        hs_on_d = ~pin_s2_q[2];
        stat_now = {int_q, oc_q, status_in};
        req_d = req_q;
        sent_d = sent_q;
        // New word only once the previous one was taken by the link side
        if ((ack_s2_q == req_q) && (stat_now != sent_q)) begin
            sent_d = stat_now;
            req_d = ~req_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
        if (!rstn_in) begin
            cmd_valid_q <= 1'b0;
            cmd_data_q <= 8'h00;
            int_q <= 1'b0;
            oc_q <= 1'b0;
            ls_on_q <= 1'b0;
            hs_on_q <= 1'b0;
            req_q <= 1'b0;
            sent_q <= `PDSP_STAT_RST;
        end else begin
            cmd_valid_q <= cmd_valid_d;
            cmd_data_q <= cmd_data_d;
            int_q <= int_d;
            oc_q <= oc_d;
            ls_on_q <= ls_on_d;
            hs_on_q <= hs_on_d;
            req_q <= req_d;
            sent_q <= sent_d;
        end
    end

    assign link.intr = int_q;
    assign link.overcurrent_flag = oc_q;
    assign cmd_valid_out = cmd_valid_q;
    assign cmd_data_out = cmd_data_q;
    assign phase_c_low_on_out = ls_on_q;
    assign phase_c_high_on_out = hs_on_q;

endmodule // pdsp_dev

//--- hw/pdsp_map.svh
`ifndef PDSP_MAP_SVH
`define PDSP_MAP_SVH

// Serial word and status layout
`define PDSP_WORD_W 8
`define PDSP_STAT_INT_BIT 7
`define PDSP_STAT_OC_BIT 6
`define PDSP_STAT_USER_W 6
`define PDSP_STAT_RST 8'h00
`define PDSP_CMD_CLR_INT 8'h6c

// Clock rates and link timing
`define PDSP_CORE_KHZ 125000
`define PDSP_SCLK_MAX_KHZ 5000
`define PDSP_SCLK_HALF ((`PDSP_CORE_KHZ + 2 * `PDSP_SCLK_MAX_KHZ - 1) / (2 * `PDSP_SCLK_MAX_KHZ))
`define PDSP_CORE_PERIOD_PS 8000
`define PDSP_T_LEAD_NS 100
`define PDSP_T_LAG_NS 100
`define PDSP_T_GAP_NS 200
`define PDSP_LEAD_CYC ((`PDSP_T_LEAD_NS * 1000 + `PDSP_CORE_PERIOD_PS - 1) / `PDSP_CORE_PERIOD_PS)
`define PDSP_LAG_CYC ((`PDSP_T_LAG_NS * 1000 + `PDSP_CORE_PERIOD_PS - 1) / `PDSP_CORE_PERIOD_PS)
`define PDSP_GAP_CYC ((`PDSP_T_GAP_NS * 1000 + `PDSP_CORE_PERIOD_PS - 1) / `PDSP_CORE_PERIOD_PS)
`define PDSP_CNT_W 5

`endif

//--- hw/pdsp_pkg.sv
package pdsp_pkg;
    typedef logic [7:0] pdsp_word_t;
    typedef logic [2:0] pdsp_bit_idx_t;
    typedef enum logic [2:0] {
        PDSP_IDLE,
        PDSP_LEAD,
        PDSP_HIGH,
        PDSP_LOW,
        PDSP_LAG,
        PDSP_GAP
    } pdsp_mst_state_t;
endpackage

//--- hw/pdsp_if.sv
`timescale 1ns/1ps
interface pdsp_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic so;
    logic so_oe;
    logic miso;
    logic phase_c_low_side_request;
    logic phase_c_high_side_request_n;
    logic overcurrent_flag;
    logic intr;

    // Released line is pulled down
    assign miso = so_oe & so;

    modport dev (
        input cs_n,
        input sclk,
        input mosi,
        output so,
        output so_oe,
        input phase_c_low_side_request,
        input phase_c_high_side_request_n,
        output overcurrent_flag,
        output intr
    );

    modport mst (
        output cs_n,
        output sclk,
        output mosi,
        input miso,
        output phase_c_low_side_request,
        output phase_c_high_side_request_n,
        input overcurrent_flag,
        input intr
    );
endinterface

//--- hw/pdsp_mst.sv
`timescale 1ns/1ps
`include "pdsp_map.svh"

module pdsp_mst
    import pdsp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    pdsp_if.mst link,
    input wire logic req_valid_in,
    input wire pdsp_word_t req_data_in,
    output logic ready_out,
    output logic rsp_valid_out,
    output pdsp_word_t rsp_data_out,
    input wire logic low_on_in,
    input wire logic high_on_in,
    output logic overcurrent_out,
    output logic intr_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;

    always_ff @(posedge core_clk_in) begin
        pin_s1_q <= {link.miso, link.overcurrent_flag, link.intr};
        pin_s2_q <= pin_s1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer; clock made by dividing the core clock
    pdsp_mst_state_t st_q, st_d;
    logic [`PDSP_CNT_W-1:0] cnt_q, cnt_d;
    pdsp_bit_idx_t bit_q, bit_d;
    pdsp_word_t txsh_q, txsh_d;
    pdsp_word_t rxsh_q, rxsh_d;
    logic cs_n_q, cs_n_d;
    logic sclk_q, sclk_d;
    logic mosi_q, mosi_d;
    logic rdy_q, rdy_d;
    logic rsp_q, rsp_d;
    pdsp_word_t rsp_data_q, rsp_data_d;
    logic ls_q, hs_n_q;
    logic oc_q, int_q;
    logic cnt_done;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q - 5'h01;
        cnt_done = (cnt_q == 5'h00);
        bit_d = bit_q;
        txsh_d = txsh_q;
        rxsh_d = rxsh_q;
        cs_n_d = cs_n_q;
        sclk_d = sclk_q;
        mosi_d = mosi_q;
        rdy_d = 1'b0;
        rsp_d = 1'b0;
        rsp_data_d = rsp_data_q;
        case (st_q)
            PDSP_IDLE: begin
                rdy_d = ~req_valid_in;
                cnt_d = cnt_q;
                if (req_valid_in && rdy_q) begin
                    txsh_d = req_data_in;
                    cs_n_d = 1'b0;
                    cnt_d = 5'(`PDSP_LEAD_CYC - 1);
                    st_d = PDSP_LEAD;
                end
            end
            PDSP_LEAD: begin
                if (cnt_done) begin
                    sclk_d = 1'b1;
                    mosi_d = txsh_q[7];
                    txsh_d = {txsh_q[6:0], 1'b0};
                    cnt_d = 5'(`PDSP_SCLK_HALF - 1);
                    st_d = PDSP_HIGH;
                end
            end
            PDSP_HIGH: begin
                if (cnt_done) begin
                    sclk_d = 1'b0;
                    rxsh_d = {rxsh_q[6:0], pin_s2_q[2]};
                    cnt_d = 5'(`PDSP_SCLK_HALF - 1);
                    st_d = PDSP_LOW;
                end
            end
            PDSP_LOW: begin
                if (cnt_done) begin
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        cnt_d = 5'(`PDSP_LAG_CYC - 1);
                        st_d = PDSP_LAG;
                    end else begin
                        sclk_d = 1'b1;
                        mosi_d = txsh_q[7];
                        txsh_d = {txsh_q[6:0], 1'b0};
                        cnt_d = 5'(`PDSP_SCLK_HALF - 1);
                        st_d = PDSP_HIGH;
                    end
                end
            end
            PDSP_LAG: begin
                if (cnt_done) begin
                    cs_n_d = 1'b1;
                    rsp_d = 1'b1;
                    rsp_data_d = rxsh_q;
                    cnt_d = 5'(`PDSP_GAP_CYC - 1);
                    st_d = PDSP_GAP;
                end
            end
            PDSP_GAP: begin
                if (cnt_done) begin
                    cnt_d = 5'h00;
                    st_d = PDSP_IDLE;
                    rdy_d = 1'b1;
                end
            end
            default: begin
                st_d = PDSP_IDLE;
                cs_n_d = 1'b1;
                sclk_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_q <= PDSP_IDLE;
            cnt_q <= 5'h00;
            bit_q <= 3'h0;
            txsh_q <= 8'h00;
            rxsh_q <= 8'h00;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            rdy_q <= 1'b0;
            rsp_q <= 1'b0;
            rsp_data_q <= 8'h00;
            ls_q <= 1'b0;
            hs_n_q <= 1'b1;
            oc_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            txsh_q <= txsh_d;
            rxsh_q <= rxsh_d;
            cs_n_q <= cs_n_d;
            sclk_q <= sclk_d;
            mosi_q <= mosi_d;
            rdy_q <= rdy_d;
            rsp_q <= rsp_d;
            rsp_data_q <= rsp_data_d;
            ls_q <= low_on_in;
            hs_n_q <= ~high_on_in;
            oc_q <= pin_s2_q[1];
            int_q <= pin_s2_q[0];
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;
    assign link.phase_c_low_side_request = ls_q;
    assign link.phase_c_high_side_request_n = hs_n_q;
    assign ready_out = rdy_q;
    assign rsp_valid_out = rsp_q;
    assign rsp_data_out = rsp_data_q;
    assign overcurrent_out = oc_q;
    assign intr_out = int_q;

endmodule // pdsp_mst

//--- sim/pdsp_checker.sv
`timescale 1ns/1ps
`include "pdsp_map.svh"

module pdsp_checker (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic so,
    input wire logic so_oe,
    input wire logic miso,
    input wire logic intr
);
    logic [4:0] lvl_q, lvl_d;
    logic [7:0] word_q, word_d;
    logic sclk_q;

    // Saturating age of the sclk level, for half-period and lag limits
    always_comb begin
        lvl_d = (sclk != sclk_q) ? 5'h00 : lvl_q + {4'h0, lvl_q != 5'h1f};
        word_d = (sclk_q && !sclk && !cs_n) ? {word_q[6:0], mosi} : word_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            lvl_q <= 5'h00;
            word_q <= 8'h00;
            sclk_q <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            word_q <= word_d;
            sclk_q <= sclk;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_cs_hi8;
        cs_n [*8];
    endsequence

    sequence s_sclk_lo8;
        !sclk [*8];
    endsequence

    chk_so_released: assert property (cs_n |-> !so_oe && !miso)
        else $error("serial out driven while deselected");
    chk_so_on_rise: assert property (so_oe && $past(so_oe) && $changed(so) |-> $rose(sclk))
        else $error("serial out moved off a rising clock");
    chk_mosi_on_rise: assert property (!cs_n && !$fell(cs_n) && $changed(mosi) |-> $rose(sclk))
        else $error("serial in moved off a rising clock");
    chk_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    chk_sclk_half_min: assert property ($changed(sclk) |-> lvl_q >= 5'h0c)
        else $error("serial clock half period too short");
    chk_lead_time: assert property ($fell(cs_n) |-> s_sclk_lo8)
        else $error("clock rose too soon after select");
    chk_lag_time: assert property ($rose(cs_n) |-> !sclk && lvl_q >= 5'h0c)
        else $error("select released too soon after clock");
    chk_frame_gap: assert property ($rose(cs_n) |=> s_cs_hi8 ##1 s_cs_hi8 ##1 s_cs_hi8)
        else $error("frames too close together");
    chk_intr_clear: assert property ($fell(intr) |-> !cs_n && word_q == `PDSP_CMD_CLR_INT)
        else $error("interrupt dropped without clear command");
endmodule // pdsp_checker

//--- sim/tb_predriver_spi_port_and_inputs.sv
`timescale 1ns/1ps
`include "pdsp_map.svh"

module tb_predriver_spi_port_and_inputs;
    import pdsp_pkg::*;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic fault_in = 1'b0;
    logic overcurrent_in = 1'b0;
    logic req_valid_in = 1'b0;
    logic low_on_in = 1'b0;
    logic high_on_in = 1'b0;
    logic [5:0] status_in = 6'h00;
    pdsp_word_t req_data_in = 8'h00;
    logic cmd_valid_out, ready_out, rsp_valid_out, overcurrent_out, intr_out, lo_on, hi_on;
    pdsp_word_t cmd_data_out, rsp_data_out, got_cmd, got_rsp, on_mosi, on_miso;
    int num_errors = 0;
    int check_count = 0;

    pdsp_if link_if();
    wire logic req_lo = link_if.phase_c_low_side_request;
    wire logic req_hi_n = link_if.phase_c_high_side_request_n;

    pdsp_dev u_pdsp_dev (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(link_if.dev),
        .status_in(status_in), .fault_in(fault_in), .overcurrent_in(overcurrent_in),
        .cmd_valid_out(cmd_valid_out), .cmd_data_out(cmd_data_out),
        .phase_c_low_on_out(lo_on), .phase_c_high_on_out(hi_on));

    pdsp_mst u_pdsp_mst (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link(link_if.mst),
        .req_valid_in(req_valid_in), .req_data_in(req_data_in), .ready_out(ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .low_on_in(low_on_in),
        .high_on_in(high_on_in), .overcurrent_out(overcurrent_out), .intr_out(intr_out));

    pdsp_checker u_pdsp_checker (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .cs_n(link_if.cs_n), .sclk(link_if.sclk), .mosi(link_if.mosi), .so(link_if.so),
        .so_oe(link_if.so_oe), .miso(link_if.miso), .intr(link_if.intr));

    initial begin
        forever #4 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input pdsp_word_t got, input pdsp_word_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(negedge core_clk_in);
    endtask

    // One frame; the wire is read at sclk falls, as the master latches it
    task automatic send(input pdsp_word_t w, input bit chk);
        logic prev;
        int n;
        prev = 1'b0;
        n = 0;
        got_cmd = ~w;
        @(posedge core_clk_in);
        req_valid_in <= 1'b1;
        req_data_in <= w;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (ready_out !== 1'b1 && n < 400);
        check({7'h0, ready_out}, 8'h01);
        @(posedge core_clk_in);
        req_valid_in <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
            if (prev && !link_if.sclk) begin
                on_mosi = {on_mosi[6:0], link_if.mosi};
                on_miso = {on_miso[6:0], link_if.miso};
            end
            prev = link_if.sclk;
            if (cmd_valid_out === 1'b1) got_cmd = cmd_data_out;
        end while (rsp_valid_out !== 1'b1 && n < 400);
        check({7'h0, rsp_valid_out}, 8'h01);
        got_rsp = rsp_data_out;
        if (chk) begin
            check(got_cmd, w);
            check(on_mosi, w);
            check(on_miso, got_rsp);
        end
    endtask

    task automatic t_words();
        pdsp_word_t ws[4] = '{8'h81, 8'h00, 8'hff, 8'h5a};
        foreach (ws[i]) send(ws[i], 1'b1);
    endtask

    task automatic t_phase();
        for (int i = 0; i < 4; i++) begin
            logic l, h;
            l = i[0];
            h = i[1];
            @(posedge core_clk_in);
            low_on_in <= l;
            high_on_in <= h;
            wait_cyc(10);
            check({6'h0, req_lo, req_hi_n}, {6'h0, l, !h});
            check({6'h0, lo_on, hi_on}, {6'h0, l, h});
        end
    endtask

    // Status can lag a frame, so two frames before each compare
    task automatic t_status();
        @(posedge core_clk_in);
        status_in <= 6'h2a;
        send(8'h11, 1'b1);
        send(8'h12, 1'b1);
        check(got_rsp, 8'h2a);
        @(posedge core_clk_in);
        overcurrent_in <= 1'b1;
        wait_cyc(10);
        check({6'h0, link_if.overcurrent_flag, overcurrent_out}, 8'h03);
        send(8'h13, 1'b1);
        send(8'h14, 1'b1);
        check(got_rsp, 8'h6a);
        @(posedge core_clk_in);
        overcurrent_in <= 1'b0;
        wait_cyc(10);
        check({6'h0, link_if.overcurrent_flag, overcurrent_out}, 8'h00);
    endtask

    task automatic t_intr();
        @(posedge core_clk_in);
        fault_in <= 1'b1;
        wait_cyc(4);
        @(posedge core_clk_in);
        fault_in <= 1'b0;
        wait_cyc(10);
        check({6'h0, link_if.intr, intr_out}, 8'h03);
        send(8'h00, 1'b1);
        send(8'h00, 1'b1);
        check(got_rsp, 8'haa);
        check({6'h0, link_if.intr, intr_out}, 8'h03);
        send(`PDSP_CMD_CLR_INT, 1'b1);
        wait_cyc(4);
        check({6'h0, link_if.intr, intr_out}, 8'h00);
    endtask

    // Reset mid-frame: the partial word must never surface
    task automatic t_abort();
        int seen;
        seen = 0;
        @(posedge core_clk_in);
        req_data_in <= 8'hc3;
        req_valid_in <= 1'b1;
        wait_cyc(100);
        check({7'h0, link_if.cs_n}, 8'h00);
        @(posedge core_clk_in);
        req_valid_in <= 1'b0;
        rstn_in <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (40) begin
            @(negedge core_clk_in);
            if (cmd_valid_out !== 1'b0) seen++;
        end
        check(seen[7:0], 8'h00);
        send(8'h3c, 1'b1);
    endtask

    initial begin
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        wait_cyc(2);
        check({4'h0, link_if.cs_n, link_if.sclk, link_if.so_oe, link_if.miso}, 8'h08);
        send(8'h00, 1'b0);
        t_words();
        t_phase();
        t_status();
        t_intr();
        t_abort();
        stop_test();
    end

    initial begin
        repeat (30000) @(posedge core_clk_in);
        num_errors++;
        stop_test();
    end
endmodule // tb_predriver_spi_port_and_inputs
